// file: src/nalu_defines.svh
// Constants of the nibble datapath: RAM map, field positions, reset values
`ifndef NALU_DEFINES_SVH
`define NALU_DEFINES_SVH
`define NALU_RAM_DEPTH      256
`define NALU_RAM_DEPTH_SM   128
`define NALU_ADDR_MSB       7
`define NALU_ADDR_LOW_MASK  8'h7f
`define NALU_ADDR_FULL_MASK 8'hff
`define NALU_IDX_WB_LAG     5
`define NALU_NIB_MSB        3
`define NALU_STACK_IDX_ADDR 8'hff
`define NALU_ROMP_HI_ADDR   8'hfe
`define NALU_ROMP_MID_ADDR  8'hfd
`define NALU_ROMP_LO_ADDR   8'hfc
`define NALU_TMR2_HI_ADDR   8'hfa
`define NALU_TMR2_MID_ADDR  8'hf9
`define NALU_TMR2_LO_ADDR   8'hf8
`define NALU_TMR1_HI_ADDR   8'hf6
`define NALU_TMR1_MID_ADDR  8'hf5
`define NALU_TMR1_LO_ADDR   8'hf4
`define NALU_STACK_TOP_BITS 2'h3
`define NALU_STACK_LOW_BITS 2'h0
`define NALU_NIB_ZERO       4'h0
`define NALU_NIB_ONE        4'h1
`define NALU_FLAGS_RESET    4'h2
`define NALU_FLAG_CARRY     3
`define NALU_FLAG_ZERO      2
`define NALU_FLAG_BRANCH    1
`define NALU_FLAG_GENERAL   0
`endif

// file: src/nalu_pkg.sv
// Types shared by the nibble datapath
package nalu_pkg;
  typedef enum logic [3:0] {
    NALU_OP_PASS, NALU_OP_ADD, NALU_OP_ADD_WITH_CARRY_INSTR, NALU_OP_SUB, NALU_OP_SUBC,
    NALU_OP_AND, NALU_OP_OR, NALU_OP_XOR, NALU_OP_ROL, NALU_OP_ROR
  } nalu_op_e;
  typedef enum logic [1:0] {
    NALU_BR_ONE, NALU_BR_ZERO, NALU_BR_CARRY, NALU_BR_BORROW
  } nalu_brsel_e;
  typedef enum logic [1:0] {
    NALU_GF_KEEP, NALU_GF_SET, NALU_GF_CLR
  } nalu_gf_e;
  typedef struct packed {
    logic        carry;
    logic        zero;
    logic        branch;
    logic        general;
  } nalu_flags_s;
  typedef struct packed {
    nalu_op_e    op;
    logic        use_mem;
    logic        acc_we;
    logic        carry_we;
    logic        zero_we;
    logic        branch_we;
    nalu_brsel_e branch_sel;
    nalu_gf_e    gf_ctl;
  } nalu_ctl_s;
endpackage

// file: src/nalu_alu.sv
// Combinational 4-bit ALU with carry and zero outputs
`timescale 1ns/1ns
`default_nettype none
`include "nalu_defines.svh"
module nalu_alu (
  // Operation
  input  wire nalu_pkg::nalu_op_e op,
  input  wire logic [3:0]         opa,
  input  wire logic [3:0]         opb,
  input  wire logic               carry_in,
  // Result
  output logic [3:0]              result,
  output logic                    carry_out,
  output logic                    zero_out
);
  logic [4:0] sum_w;
  logic [4:0] dif_w;
  logic       cin_w;
  logic       sub_cin_w;

  // Carry in for carried add and subtract
  assign cin_w     = (op == nalu_pkg::NALU_OP_ADD_WITH_CARRY_INSTR) ? carry_in : 1'b0;
  assign sub_cin_w = (op == nalu_pkg::NALU_OP_SUBC) ? carry_in : 1'b1;
  assign sum_w     = {1'b0, opa} + {1'b0, opb} + {4'h0, cin_w};
  assign dif_w     = {1'b0, opa} + {1'b0, ~opb} + {4'h0, sub_cin_w};

  // Operation select
  always_comb
  begin
    result    = opb;
    carry_out = carry_in;
    unique case (op)
      nalu_pkg::NALU_OP_PASS: result = opb;
      nalu_pkg::NALU_OP_ADD, nalu_pkg::NALU_OP_ADD_WITH_CARRY_INSTR:
      begin
        result    = sum_w[3:0];
        carry_out = sum_w[4];
      end
      nalu_pkg::NALU_OP_SUB, nalu_pkg::NALU_OP_SUBC:
      begin
        result    = dif_w[3:0];
        carry_out = dif_w[4];
      end
      nalu_pkg::NALU_OP_AND: result = opa & opb;
      nalu_pkg::NALU_OP_OR:  result = opa | opb;
      nalu_pkg::NALU_OP_XOR: result = opa ^ opb;
      nalu_pkg::NALU_OP_ROL:
      begin
        result    = {opa[2:0], carry_in};
        carry_out = opa[3];
      end
      nalu_pkg::NALU_OP_ROR:
      begin
        result    = {carry_in, opa[3:1]};
        carry_out = opa[0];
      end
      default:
      begin
        result    = opb;
        carry_out = carry_in;
      end
    endcase
  end

  // Zero detect on the result
  assign zero_out = (result == `NALU_NIB_ZERO);
endmodule
`default_nettype wire

// file: src/nalu_ram.sv
// Nibble data memory with top address bit dropped on the small variant
`timescale 1ns/1ns
`default_nettype none
`include "nalu_defines.svh"
module nalu_ram (
  // Clock
  input  wire logic       core_clk,
  // Access
  input  wire logic       small_variant,
  input  wire logic [7:0] addr,
  input  wire logic       we,
  input  wire logic [3:0] wdata,
  output logic [3:0]      rdata,
  // Table pointer nibbles
  output logic [11:0]     romp_word
);
  logic [3:0] mem_q [`NALU_RAM_DEPTH];
  logic [7:0] phys_w;
  logic [7:0] fold_w;

  // Pointer taps fold like any other access on the small part
  assign fold_w    = small_variant ? `NALU_ADDR_LOW_MASK : `NALU_ADDR_FULL_MASK;
  assign romp_word = {mem_q[`NALU_ROMP_HI_ADDR & fold_w], mem_q[`NALU_ROMP_MID_ADDR & fold_w],
                      mem_q[`NALU_ROMP_LO_ADDR & fold_w]};

  // Small part leaves the address MSB undecoded
  assign phys_w = small_variant ? {1'b0, addr[6:0]} : addr;
  assign rdata  = mem_q[phys_w];

  // Write port, no reset as on the real store
  always_ff @(posedge core_clk)
  begin
    if (we)
      mem_q[phys_w] <= wdata;
  end
endmodule
`default_nettype wire

// file: src/nalu_core.sv
// Nibble datapath: work register, flags, RAM-mapped special words, stack
`timescale 1ns/1ns
`default_nettype none
`include "nalu_defines.svh"
module nalu_core (
  // Clock and reset
  input  wire logic                core_clk,
  input  wire logic                arst_n,
  // Variant strap
  input  wire logic                small_variant,
  // Instruction controls
  input  wire nalu_pkg::nalu_ctl_s ctl,
  input  wire logic                exec,
  // RAM access by ordinary instructions
  input  wire logic [7:0]          ram_addr,
  input  wire logic                ram_we,
  input  wire logic                ram_wsel_acc,
  input  wire logic [3:0]          ram_wdata,
  // Stack traffic
  input  wire logic                push_req,
  input  wire logic                pop_req,
  input  wire logic                push_is_int,
  input  wire logic                pop_is_interrupt_return_instr,
  input  wire logic [11:0]         ret_addr,
  // Table pointer sampling
  input  wire logic                romp_load,
  // Results
  output logic [3:0]               work_register,
  output nalu_pkg::nalu_flags_s    flags,
  output logic                     branch_taken,
  output logic [3:0]               ram_rdata,
  output logic [11:0]              rom_table_pointer,
  output logic [11:0]              restored_addr,
  output logic                     stack_busy
);
  // ****************************************************************
  // Local state
  // ****************************************************************
  typedef enum logic [2:0] {
    NALU_ST_IDLE, NALU_ST_IDX_RD, NALU_ST_WORD, NALU_ST_IDX_WR
  } nalu_stk_e;

  nalu_stk_e              st_q, st_d;
  logic [3:0]             acc_q, acc_d;
  nalu_pkg::nalu_flags_s  flg_q, flg_d;
  logic                   br_q;
  logic [3:0]             rd_q;
  logic [11:0]            romp_q;
  logic [11:0]            rest_q, rest_d;
  logic                   busy_q;
  logic [3:0]             idx_q, idx_d;
  logic [1:0]             wcnt_q, wcnt_d;
  logic                   is_push_q, is_push_d;
  logic                   is_int_q, is_int_d;
  logic [11:0]            ret_q, ret_d;

  // ****************************************************************
  // ALU and RAM
  // ****************************************************************
  logic [3:0]  alu_res_w;
  logic        alu_c_w;
  logic        alu_z_w;
  logic [3:0]  opb_w;
  logic [7:0]  stk_addr_w;
  logic [7:0]  mem_addr_w;
  logic        mem_we_w;
  logic [3:0]  mem_wd_w;
  logic [3:0]  mem_rd_w;
  logic [3:0]  stk_wd_w;
  logic        br_cond_w;
  logic [11:0] romp_word_w;

  // Second operand from memory or instruction data
  assign opb_w = ctl.use_mem ? mem_rd_w : ram_wdata;

  nalu_alu u_alu (
    .op        (ctl.op),
    .opa       (acc_q),
    .opb       (opb_w),
    .carry_in  (flg_q.carry),
    .result    (alu_res_w),
    .carry_out (alu_c_w),
    .zero_out  (alu_z_w)
  );

  // Stack address: ones above, index in middle, word select below
  assign stk_addr_w = {`NALU_STACK_TOP_BITS, idx_q, wcnt_q};

  // Stack word data: return address nibbles, then flags on interrupt
  always_comb
  begin
    stk_wd_w = ret_q[3:0];
    unique case (wcnt_q)
      2'h0: stk_wd_w = ret_q[3:0];
      2'h1: stk_wd_w = ret_q[7:4];
      2'h2: stk_wd_w = ret_q[11:8];
      2'h3: stk_wd_w = is_int_q ? flg_q : `NALU_NIB_ZERO;
      default: stk_wd_w = ret_q[3:0];
    endcase
  end

  // Memory port arbitration: stack engine wins while busy
  assign mem_addr_w = (st_q == NALU_ST_IDLE) ? ram_addr :
                      (st_q == NALU_ST_WORD) ? stk_addr_w : `NALU_STACK_IDX_ADDR;
  assign mem_we_w   = (st_q == NALU_ST_IDLE) ? (ram_we && exec) :
                      ((st_q == NALU_ST_WORD) && is_push_q) || (st_q == NALU_ST_IDX_WR);
  assign mem_wd_w   = (st_q == NALU_ST_IDLE) ? (ram_wsel_acc ? acc_q : ram_wdata) :
                      (st_q == NALU_ST_WORD) ? stk_wd_w : idx_q;

  nalu_ram u_ram (
    .core_clk      (core_clk),
    .small_variant (small_variant),
    .addr          (mem_addr_w),
    .we            (mem_we_w),
    .wdata         (mem_wd_w),
    .rdata         (mem_rd_w),
    .romp_word     (romp_word_w)
  );

  // ****************************************************************
  // Work register and flags
  // ****************************************************************
  // Branch flag condition select
  always_comb
  begin
    br_cond_w = 1'b1;
    unique case (ctl.branch_sel)
      nalu_pkg::NALU_BR_ONE:    br_cond_w = 1'b1;
      nalu_pkg::NALU_BR_ZERO:   br_cond_w = ~alu_z_w;
      nalu_pkg::NALU_BR_CARRY:  br_cond_w = ~alu_c_w;
      nalu_pkg::NALU_BR_BORROW: br_cond_w = alu_c_w;
      default:                  br_cond_w = 1'b1;
    endcase
  end

  // Next work register and flags
  always_comb
  begin
    acc_d = acc_q;
    flg_d = flg_q;
    if (st_q == NALU_ST_IDLE && exec)
    begin
      if (ctl.acc_we)
        acc_d = alu_res_w;
      if (ctl.carry_we)
        flg_d.carry = alu_c_w;
      if (ctl.zero_we)
        flg_d.zero = alu_z_w;
      if (ctl.branch_we)
        flg_d.branch = br_cond_w;
      if (ctl.gf_ctl == nalu_pkg::NALU_GF_SET)
        flg_d.general = 1'b1;
      else if (ctl.gf_ctl == nalu_pkg::NALU_GF_CLR)
        flg_d.general = 1'b0;
    end
    if (st_q == NALU_ST_IDX_WR && is_push_q && is_int_q)
      flg_d.branch = 1'b1;
    if (st_q == NALU_ST_WORD && !is_push_q && is_int_q && wcnt_q == 2'h3)
      flg_d = mem_rd_w;
  end

  // ****************************************************************
  // Stack engine
  // ****************************************************************
  // Sequence: read index, walk four words, write index back
  always_comb
  begin
    st_d      = st_q;
    idx_d     = idx_q;
    wcnt_d    = wcnt_q;
    is_push_d = is_push_q;
    is_int_d  = is_int_q;
    ret_d     = ret_q;
    rest_d    = rest_q;
    unique case (st_q)
      NALU_ST_IDLE:
      begin
        if (push_req || pop_req)
        begin
          st_d      = NALU_ST_IDX_RD;
          is_push_d = push_req;
          is_int_d  = push_req ? push_is_int : pop_is_interrupt_return_instr;
          ret_d     = ret_addr;
        end
      end
      NALU_ST_IDX_RD:
      begin
        // Restore pre-increments the index
        idx_d  = is_push_q ? mem_rd_w : mem_rd_w + `NALU_NIB_ONE;
        wcnt_d = 2'h0;
        st_d   = NALU_ST_WORD;
      end
      NALU_ST_WORD:
      begin
        if (!is_push_q)
        begin
          unique case (wcnt_q)
            2'h0: rest_d[3:0]  = mem_rd_w;
            2'h1: rest_d[7:4]  = mem_rd_w;
            2'h2: rest_d[11:8] = mem_rd_w;
            default: rest_d = rest_q;
          endcase
        end
        wcnt_d = wcnt_q + 2'h1;
        if (wcnt_q == 2'h3)
          st_d = NALU_ST_IDX_WR;
      end
      NALU_ST_IDX_WR:
      begin
        st_d = NALU_ST_IDLE;
      end
      default: st_d = NALU_ST_IDLE;
    endcase
  end

  // Index written back: decremented after a save
  logic [3:0] idx_wb_w;
  assign idx_wb_w = is_push_q ? idx_q - `NALU_NIB_ONE : idx_q;

  // ****************************************************************
  // Registers
  // ****************************************************************
  // State and datapath registers
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_q      <= NALU_ST_IDLE;
      acc_q     <= `NALU_NIB_ZERO;
      flg_q     <= `NALU_FLAGS_RESET;
      idx_q     <= `NALU_NIB_ZERO;
      wcnt_q    <= 2'h0;
      is_push_q <= 1'b0;
      is_int_q  <= 1'b0;
      ret_q     <= 12'h000;
      rest_q    <= 12'h000;
    end
    else
    begin
      st_q      <= st_d;
      acc_q     <= acc_d;
      flg_q     <= flg_d;
      idx_q     <= (st_q == NALU_ST_WORD && wcnt_q == 2'h3) ? idx_wb_w : idx_d;
      wcnt_q    <= wcnt_d;
      is_push_q <= is_push_d;
      is_int_q  <= is_int_d;
      ret_q     <= ret_d;
      rest_q    <= rest_d;
    end
  end

  // Registered outputs and table pointer capture
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      br_q   <= 1'b0;
      rd_q   <= `NALU_NIB_ZERO;
      romp_q <= 12'h000;
      busy_q <= 1'b0;
    end
    else
    begin
      br_q   <= flg_d.branch;
      rd_q   <= mem_rd_w;
      busy_q <= (st_d != NALU_ST_IDLE);
      if (romp_load)
        romp_q <= romp_word_w;
    end
  end

  assign work_register     = acc_q;
  assign flags             = flg_q;
  assign branch_taken      = br_q;
  assign ram_rdata         = rd_q;
  assign rom_table_pointer = romp_q;
  assign restored_addr     = rest_q;
  assign stack_busy        = busy_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  AST_STACK_ADDR: assert property (@(posedge core_clk) disable iff (!arst_n)
    st_q == NALU_ST_WORD |-> mem_addr_w[7:6] == 2'h3 && mem_addr_w[5:2] == idx_q)
    else $error("stack address format wrong");
  AST_ACC_LOAD: assert property (@(posedge core_clk) disable iff (!arst_n)
    st_q == NALU_ST_IDLE && exec && ctl.acc_we |=> acc_q == $past(alu_res_w))
    else $error("work register not loaded");
  AST_ZERO_FLAG: assert property (@(posedge core_clk) disable iff (!arst_n)
    st_q == NALU_ST_IDLE && exec && ctl.zero_we |=> flg_q.zero == ($past(alu_res_w) == 4'h0))
    else $error("zero flag mismatch");
  AST_CARRY_ADD: assert property (@(posedge core_clk) disable iff (!arst_n)
    ctl.op == nalu_pkg::NALU_OP_ADD |-> alu_c_w == (({1'b0, acc_q} + {1'b0, opb_w}) > 5'h0f))
    else $error("add carry wrong");
  AST_BORROW: assert property (@(posedge core_clk) disable iff (!arst_n)
    ctl.op == nalu_pkg::NALU_OP_SUB |-> alu_c_w == (acc_q >= opb_w))
    else $error("subtract carry wrong");
  AST_KEEP_FLAGS: assert property (@(posedge core_clk) disable iff (!arst_n)
    st_q == NALU_ST_IDLE && !(exec && (ctl.carry_we || ctl.zero_we || ctl.branch_we))
    && ctl.gf_ctl == nalu_pkg::NALU_GF_KEEP |=> $stable(flg_q))
    else $error("flag changed without update");
  AST_PUSH_SF: assert property (@(posedge core_clk) disable iff (!arst_n)
    st_q == NALU_ST_IDX_WR && is_push_q && is_int_q |=> flg_q.branch)
    else $error("branch flag not set after push");
  AST_PUSH_DEC: assert property (@(posedge core_clk) disable iff (!arst_n)
    st_q == NALU_ST_IDX_WR && is_push_q |-> mem_we_w
    && mem_wd_w == $past(mem_rd_w, `NALU_IDX_WB_LAG) - `NALU_NIB_ONE)
    else $error("index write back wrong");
  AST_POP_INC: assert property (@(posedge core_clk) disable iff (!arst_n)
    st_q == NALU_ST_IDX_WR && !is_push_q |-> mem_we_w
    && mem_wd_w == $past(mem_rd_w, `NALU_IDX_WB_LAG) + `NALU_NIB_ONE)
    else $error("index restore increment wrong");
  AST_ROL_CARRY: assert property (@(posedge core_clk) disable iff (!arst_n)
    ctl.op == nalu_pkg::NALU_OP_ROL |-> alu_c_w == acc_q[`NALU_NIB_MSB])
    else $error("rotate carry wrong");
  AST_GF_SET: assert property (@(posedge core_clk) disable iff (!arst_n)
    st_q == NALU_ST_IDLE && exec && ctl.gf_ctl == nalu_pkg::NALU_GF_SET |=> flg_q.general)
    else $error("general flag not set");
endmodule
`default_nettype wire

// file: test/nalu_seq_model.sv
// Behavioural instruction sequencer driving the nibble datapath
`timescale 1ns/1ns
`default_nettype none
module nalu_seq_model (
  // Clock and status
  input  wire logic                core_clk,
  input  wire logic                stack_busy,
  input  wire logic [3:0]          ram_rdata,
  // Instruction controls
  output var  nalu_pkg::nalu_ctl_s ctl,
  output var  logic                exec,
  output var  logic [7:0]          ram_addr,
  output var  logic                ram_we,
  output var  logic                ram_wsel_acc,
  output var  logic [3:0]          ram_wdata,
  // Stack and pointer requests
  output var  logic                push_req,
  output var  logic                pop_req,
  output var  logic                push_is_int,
  output var  logic                pop_is_interrupt_return_instr,
  output var  logic [11:0]         ret_addr,
  output var  logic                romp_load
);
  // Idle levels at time zero
  initial
  begin
    ctl = '0;
    {exec, ram_addr, ram_we, ram_wsel_acc, ram_wdata} = '0;
    {push_req, pop_req, push_is_int, pop_is_interrupt_return_instr, ret_addr, romp_load} = '0;
  end

  // One instruction; data bus shows a changed value once released
  task automatic run(input nalu_pkg::nalu_ctl_s c, input logic [7:0] a, input logic [1:0] w,
                     input logic [3:0] d);
    @(posedge core_clk);
    ctl <= c;
    ram_addr <= a;
    {ram_we, ram_wsel_acc} <= w;
    ram_wdata <= d;
    exec <= 1'b1;
    @(posedge core_clk);
    exec <= 1'b0;
    ram_we <= 1'b0;
    ram_wdata <= ~d;
    #1;
  endtask

  // Stack save or restore, then wait for the engine to go idle
  task automatic stack(input logic pop, input logic intr, input logic [11:0] ra);
    @(posedge core_clk);
    push_req <= ~pop;
    pop_req <= pop;
    push_is_int <= intr;
    pop_is_interrupt_return_instr <= intr;
    ret_addr <= ra;
    @(posedge core_clk);
    push_req <= 1'b0;
    pop_req <= 1'b0;
    ret_addr <= ~ra;
    #1;
    for (int n = 0; n < 12 && stack_busy !== 1'b0; n++)
      @(posedge core_clk) #1;
  endtask

  // Registered RAM read, one cycle late
  task automatic peek(input logic [7:0] a, output logic [3:0] d);
    @(posedge core_clk);
    ram_addr <= a;
    @(posedge core_clk);
    #1 d = ram_rdata;
  endtask

  // Table pointer sample pulse
  task automatic load_ptr();
    @(posedge core_clk);
    romp_load <= 1'b1;
    @(posedge core_clk);
    romp_load <= 1'b0;
    #1;
  endtask
endmodule
`default_nettype wire

// file: test/nibble_alu_flags_ram_map_tb.sv
// Self-checking testbench of the nibble datapath
`timescale 1ns/1ns
`default_nettype none
module nibble_alu_flags_ram_map_tb;
  logic                  core_clk = 1'b0;
  logic                  arst_n = 1'b0;
  logic                  small_variant = 1'b0;
  nalu_pkg::nalu_ctl_s   ctl;
  nalu_pkg::nalu_flags_s flags;
  logic                  exec, ram_we, ram_wsel_acc, push_req, pop_req, push_is_int, pop_is_interrupt_return_instr;
  logic                  romp_load, branch_taken, stack_busy;
  logic [7:0]            ram_addr;
  logic [3:0]            ram_wdata, work_register, ram_rdata, rd;
  logic [11:0]           ret_addr, rom_table_pointer, restored_addr;
  int                    errors = 0;
  int                    samples_checked = 0;
  // Format: op, operand a, operand b, carry in
  localparam logic [15:0] ALU_TBL [16] = '{16'h1450, 16'h1790, 16'h3310, 16'h3220, 16'h3680,
    16'h2f01, 16'h2230, 16'h4550, 16'h4551, 16'h5ca1, 16'h6c30, 16'h7ff0, 16'h8800, 16'h8701,
    16'h9100, 16'h9e01};
  localparam logic [7:0]  TMR [6] = '{8'hf4, 8'hf5, 8'hf6, 8'hf8, 8'hf9, 8'hfa};

  // Clock, 40 ns period
  always #20 core_clk = ~core_clk;

  nalu_core dut (.core_clk, .arst_n, .small_variant, .ctl, .exec, .ram_addr, .ram_we, .ram_wsel_acc,
    .ram_wdata, .push_req, .pop_req, .push_is_int, .pop_is_interrupt_return_instr, .ret_addr, .romp_load, .work_register,
    .flags, .branch_taken, .ram_rdata, .rom_table_pointer, .restored_addr, .stack_busy);

  nalu_seq_model seq (.core_clk, .stack_busy, .ram_rdata, .ctl, .exec, .ram_addr, .ram_we, .ram_wsel_acc,
    .ram_wdata, .push_req, .pop_req, .push_is_int, .pop_is_interrupt_return_instr, .ret_addr, .romp_load);

  // ****************************************
  // Compare and helper tasks
  // ****************************************
  task automatic chk_nib(input logic [3:0] g, input logic [3:0] e);
    samples_checked++;
    if (g !== e)
    begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic chk_word(input logic [11:0] g, input logic [11:0] e);
    samples_checked++;
    if (g !== e)
    begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  function automatic nalu_pkg::nalu_ctl_s mk(input nalu_pkg::nalu_op_e o, input logic [4:0] w,
                                             input nalu_pkg::nalu_brsel_e b, input nalu_pkg::nalu_gf_e g);
    mk = '{o, w[4], w[3], w[2], w[1], w[0], b, g};
  endfunction

  // Load work register and zero flag
  task automatic ld(input logic [3:0] d);
    seq.run(mk(nalu_pkg::NALU_OP_PASS, 5'b01010, nalu_pkg::NALU_BR_ONE, nalu_pkg::NALU_GF_KEEP), 8'h00, 2'b00, d);
  endtask

  // Plain RAM write of instruction data; work register and flags are left alone
  task automatic wr(input logic [7:0] a, input logic [3:0] d);
    seq.run(mk(nalu_pkg::NALU_OP_PASS, 5'b00000, nalu_pkg::NALU_BR_ONE, nalu_pkg::NALU_GF_KEEP), a, 2'b10, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [3:0] e);
    seq.peek(a, rd);
    chk_nib(rd, e);
  endtask

  task automatic do_reset(input logic sv);
    @(posedge core_clk);
    arst_n <= 1'b0;
    small_variant <= sv;
    repeat (5) @(posedge core_clk);
    arst_n <= 1'b1;
    #1;
  endtask

  task automatic tally_and_finish();
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  // Every op except pass with carry preset, result, carry, zero and branch checked
  task automatic t_alu();
    nalu_pkg::nalu_op_e    o;
    nalu_pkg::nalu_brsel_e bs;
    logic [3:0]            a, b;
    logic                  ci, rot, lg, eb;
    logic [4:0]            r;
    for (int i = 0; i < 16; i++)
    begin
      o = nalu_pkg::nalu_op_e'(ALU_TBL[i][15:12]);
      a = ALU_TBL[i][11:8];
      b = ALU_TBL[i][7:4];
      ci = ALU_TBL[i][0];
      rot = (o == nalu_pkg::NALU_OP_ROL) || (o == nalu_pkg::NALU_OP_ROR);
      lg = o inside {nalu_pkg::NALU_OP_AND, nalu_pkg::NALU_OP_OR, nalu_pkg::NALU_OP_XOR};
      case (o)
        nalu_pkg::NALU_OP_ADD:  r = {1'b0, a} + {1'b0, b};
        nalu_pkg::NALU_OP_ADD_WITH_CARRY_INSTR: r = {1'b0, a} + {1'b0, b} + {4'h0, ci};
        nalu_pkg::NALU_OP_SUB:  r = {1'b0, a} + {1'b0, ~b} + 5'h01;
        nalu_pkg::NALU_OP_SUBC: r = {1'b0, a} + {1'b0, ~b} + {4'h0, ci};
        nalu_pkg::NALU_OP_AND:  r = {ci, a & b};
        nalu_pkg::NALU_OP_OR:   r = {ci, a | b};
        nalu_pkg::NALU_OP_XOR:  r = {ci, a ^ b};
        nalu_pkg::NALU_OP_ROL:  r = {a[3], a[2:0], ci};
        default:                r = {a[0], ci, a[3:1]};
      endcase
      if (rot)
        bs = nalu_pkg::NALU_BR_ONE;
      else if (lg)
        bs = nalu_pkg::NALU_BR_ZERO;
      else if (o == nalu_pkg::NALU_OP_ADD || o == nalu_pkg::NALU_OP_ADD_WITH_CARRY_INSTR)
        bs = nalu_pkg::NALU_BR_CARRY;
      else
        bs = nalu_pkg::NALU_BR_BORROW;
      eb = rot ? 1'b1 : lg ? (r[3:0] != 4'h0) : (bs == nalu_pkg::NALU_BR_CARRY) ? ~r[4] : r[4];
      ld(4'hf);
      seq.run(mk(nalu_pkg::NALU_OP_ADD, 5'b00100, bs, nalu_pkg::NALU_GF_KEEP), 8'h00, 2'b00, {3'h0, ci});
      ld(a);
      seq.run(mk(o, {1'b0, 1'b1, ~lg, 1'b1, 1'b1}, bs, nalu_pkg::NALU_GF_KEEP), 8'h00, 2'b00, b);
      chk_nib(work_register, r[3:0]);
      chk_nib({flags.carry, flags.zero, flags.branch, branch_taken}, {r[4], r[3:0] == 4'h0, eb, eb});
    end
  endtask

  // General flag and untouched flags
  task automatic t_flags();
    ld(4'hf);
    seq.run(mk(nalu_pkg::NALU_OP_ADD, 5'b01111, nalu_pkg::NALU_BR_CARRY, nalu_pkg::NALU_GF_SET), 8'h00, 2'b00, 4'h1);
    chk_nib(flags, 4'hd);
    seq.run(mk(nalu_pkg::NALU_OP_ADD, 5'b00000, nalu_pkg::NALU_BR_ZERO, nalu_pkg::NALU_GF_CLR), 8'h00, 2'b00, 4'h5);
    chk_nib(flags, 4'hc);
    seq.run(mk(nalu_pkg::NALU_OP_SUB, 5'b00000, nalu_pkg::NALU_BR_BORROW, nalu_pkg::NALU_GF_SET), 8'h00, 2'b00, 4'h5);
    chk_nib(flags, 4'hd);
    chk_nib(work_register, 4'h0);
  endtask

  // Interrupt save, plain call, plain return, interrupt return
  task automatic t_stack();
    logic [3:0] w [4];
    w = '{4'h3, 4'ha, 4'h5, 4'hd};
    wr(8'hff, 4'hc);
    seq.stack(1'b0, 1'b1, 12'h5a3);
    chk_nib({3'h0, stack_busy}, 4'h0);
    chk_nib(flags, 4'hf);
    rdc(8'hff, 4'hb);
    for (int k = 0; k < 4; k++)
      rdc({2'b11, 4'hc, k[1:0]}, w[k]);
    seq.run(mk(nalu_pkg::NALU_OP_PASS, 5'b00000, nalu_pkg::NALU_BR_ONE, nalu_pkg::NALU_GF_CLR), 8'h00, 2'b00, 4'h0);
    seq.stack(1'b0, 1'b0, 12'h0e1);
    rdc(8'hec, 4'h1);
    rdc(8'hef, 4'h0);
    seq.stack(1'b1, 1'b0, 12'h000);
    chk_word(restored_addr, 12'h0e1);
    chk_nib(flags, 4'he);
    seq.stack(1'b1, 1'b1, 12'h000);
    chk_word(restored_addr, 12'h5a3);
    chk_nib(flags, 4'hd);
    rdc(8'hff, 4'hc);
  endtask

  // Table pointer, timer words, memory operand and work register store
  task automatic t_mem();
    wr(8'hfe, 4'h7);
    wr(8'hfd, 4'h2);
    wr(8'hfc, 4'h9);
    seq.load_ptr();
    chk_word(rom_table_pointer, 12'h729);
    for (int i = 0; i < 6; i++)
      wr(TMR[i], TMR[i][3:0] ^ 4'h9);
    for (int i = 0; i < 6; i++)
      rdc(TMR[i], TMR[i][3:0] ^ 4'h9);
    wr(8'h10, 4'h6);
    ld(4'h3);
    seq.run(mk(nalu_pkg::NALU_OP_ADD, 5'b11000, nalu_pkg::NALU_BR_ONE, nalu_pkg::NALU_GF_KEEP), 8'h10, 2'b00, 4'h0);
    seq.run(mk(nalu_pkg::NALU_OP_PASS, 5'b00000, nalu_pkg::NALU_BR_ONE, nalu_pkg::NALU_GF_KEEP), 8'h11, 2'b11, 4'h0);
    rdc(8'h11, 4'h9);
  endtask

  // Small part: upper half of the map folds onto the lower half
  task automatic t_small();
    do_reset(1'b1);
    chk_nib(flags, 4'h2);
    wr(8'h7e, 4'h4);
    rdc(8'hfe, 4'h4);
    wr(8'hfd, 4'h8);
    rdc(8'h7d, 4'h8);
    wr(8'h7c, 4'h1);
    seq.load_ptr();
    chk_word(rom_table_pointer, 12'h481);
  endtask

  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  initial
  begin
    do_reset(1'b0);
    chk_nib(work_register, 4'h0);
    chk_nib(flags, 4'h2);
    t_alu();
    t_flags();
    t_stack();
    t_mem();
    t_small();
    tally_and_finish();
  end

  initial
  begin
    #100000;
    errors++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
